//--- logic/poe_encoder.sv
// Position output encoder: linearization, PWM/SENT timing, diagnostics
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module poe_encoder
   import poe_pkg::*;
#(
   parameter int CLK_HZ = 125_000_000
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [14:0] position,
   input  wire logic [10:0] fail_in,
   output logic             pwm_out,
   output logic             pwm_oe_n,
   output logic             irq,
   output logic [11:0]      lin_value,
   output logic             sent_select,
   output logic             sent_six,
   output logic             sent_layout,
   output logic             sent_frame_tick,
   output logic [2:0]       err_code
);
   if (CLK_HZ < 1_000_000) begin : g_chk
      $error("CLK_HZ too low for the PWM resolution");
   end
   // Doubled slowest period must still fit the 24-bit counter
   if (CLK_HZ > 1_600_000_000) begin : g_chk_hi
      $error("CLK_HZ too high for the doubled period counter");
   end

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [15:0] setup_reg, format_reg;
   logic [5:0]  sp_idx_reg;
   logic [11:0] sp_mem [POE_NSP];
   logic [10:0] chk_en_reg;
   logic [2:0]  stat_reg, en_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg, pslverr_reg;
   logic [11:0] lin_reg;
   poe_err_t    err_code_reg;

   // Decode; writes land on the access edge that sees pready high
   wire setup_ph = psel & ~penable;
   wire wr_acc   = psel & penable & pwrite & pready_reg;
   wire hit_set  = paddr == POE_FIRST_SETUP_OFS;
   wire hit_fmt  = paddr == POE_FORMAT_OFS;
   wire hit_idx  = paddr == POE_SP_INDEX_OFS;
   wire hit_dat  = paddr == POE_SP_DATA_OFS;
   wire hit_chk  = paddr == POE_CHECK_EN_OFS;
   wire hit_sta  = paddr == POE_IRQ_STAT_OFS;
   wire hit_clr  = paddr == POE_IRQ_CLR_OFS;
   wire hit_en   = paddr == POE_IRQ_EN_OFS;
   wire hit_st   = paddr == POE_STATE_OFS;
   wire mapped   = hit_set | hit_fmt | hit_idx | hit_dat | hit_chk
                 | hit_sta | hit_clr | hit_en | hit_st;
   wire sp_ok    = sp_idx_reg < 6'(POE_NSP);
   wire wr_dat   = wr_acc & hit_dat & sp_ok;
   wire [31:0] rd_mux =
        hit_set ? {16'h0000, setup_reg}
      : hit_fmt ? {16'h0000, format_reg}
      : hit_idx ? {26'h000_0000, sp_idx_reg}
      : hit_dat ? {20'h0_0000, sp_ok ? sp_mem[sp_idx_reg[5:0]] : 12'h000}
      : hit_chk ? {21'h00_0000, chk_en_reg}
      : hit_sta ? {29'h0000_0000, stat_reg}
      : hit_en  ? {29'h0000_0000, en_reg}
      : hit_st  ? {17'h0_0000, err_code_reg, lin_reg}
      : 32'h0000_0000;

   // Answer one cycle after setup; data held in a flop for a clean output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= setup_ph;
         pslverr_reg <= setup_ph & ~mapped;
         if (setup_ph)
            prdata_reg <= rd_mux;
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_reg  <= POE_FIRST_SETUP_RST;
         format_reg <= POE_FORMAT_RST;
         chk_en_reg <= POE_CHECK_EN_RST;
         en_reg     <= 3'b000;
         sp_idx_reg <= 6'h00;
      end else if (wr_acc) begin
         if (hit_set) setup_reg  <= pwdata[15:0];
         if (hit_fmt) format_reg <= pwdata[15:0];
         if (hit_chk) chk_en_reg <= pwdata[10:0];
         if (hit_en)  en_reg     <= pwdata[2:0];
         if (hit_idx) sp_idx_reg <= pwdata[5:0];
         // Index steps on so a table loads with one burst of writes
         if (wr_dat)  sp_idx_reg <= sp_idx_reg + 6'h01;
      end
   end

   // Setpoint table; cleared at reset, loaded by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < POE_NSP; i++) sp_mem[i] <= 12'h000;
      end else if (wr_dat) begin
         sp_mem[sp_idx_reg] <= pwdata[11:0];
      end
   end

   // ------------------------------------------------------------------
   // Linearization
   // ------------------------------------------------------------------
   // Segment from the top bits, weight from the low ten
   wire [4:0]  seg   = position[14:POE_SEG_SHIFT];
   wire [9:0]  frac  = position[POE_SEG_SHIFT-1:0];
   wire [11:0] sp_lo = sp_mem[seg];
   wire [11:0] sp_hi = sp_mem[6'(seg) + 6'h01];
   wire signed [12:0] diff = $signed({1'b0, sp_hi}) - $signed({1'b0, sp_lo});
   wire signed [23:0] prod = diff * $signed({1'b0, frac});
   // Arithmetic shift keeps falling curves right
   wire signed [13:0] step = 14'(prod >>> POE_SEG_SHIFT);
   wire [11:0] lin_next = 12'($signed({2'b00, sp_lo}) + step);

   // ------------------------------------------------------------------
   // Diagnostics
   // ------------------------------------------------------------------
   // Customer checks gated; undervoltage never can be
   wire [10:0] gate;
   assign gate[POE_F_NVM]    = setup_reg[POE_B_NVM_TEST];
   assign gate[POE_F_OV]     = ~setup_reg[POE_B_OV_DIS];
   assign gate[POE_F_UV]     = 1'b1;
   assign gate[POE_F_ROM]    = chk_en_reg[POE_F_ROM];
   assign gate[POE_F_STUCK]  = chk_en_reg[POE_F_STUCK];
   assign gate[POE_F_FSM]    = chk_en_reg[POE_F_FSM];
   assign gate[POE_F_SUPMON] = chk_en_reg[POE_F_SUPMON];
   assign gate[POE_F_FLOW]   = chk_en_reg[POE_F_FLOW];
   assign gate[POE_F_FHIGH]  = chk_en_reg[POE_F_FHIGH];
   assign gate[POE_F_TEMP]   = chk_en_reg[POE_F_TEMP];
   assign gate[POE_F_CLIP]   = chk_en_reg[POE_F_CLIP];
   wire [10:0] fail = fail_in & gate;
   wire        uv   = fail[POE_F_UV];
   // Mask hides display, except undervoltage which is a reset
   wire shown = ~setup_reg[POE_B_DIAG_MASK];

   // One code by list order; undervoltage overrides as a reset
   poe_err_t err_next;
   assign err_next =
        uv                 ? POE_E_UV
      : ~shown             ? POE_E_NONE
      : |fail[4:0]         ? POE_E_MEM
      : fail[POE_F_FLOW]   ? POE_E_FLOW
      : fail[POE_F_FHIGH]  ? POE_E_FHIGH
      : fail[POE_F_OV]     ? POE_E_OV
      : fail[POE_F_TEMP]   ? POE_E_TEMP
      : fail[POE_F_CLIP]   ? POE_E_CLIP
      : POE_E_NONE;

   // Error duty in tenths of a percent
   logic [9:0] duty_pm;
   always_comb begin
      case (err_code_reg)
         POE_E_MEM:   duty_pm = 10'(POE_DUTY_MEM);
         POE_E_FLOW:  duty_pm = 10'(POE_DUTY_FLOW);
         POE_E_FHIGH: duty_pm = 10'(POE_DUTY_FHIGH);
         POE_E_OV:    duty_pm = 10'(POE_DUTY_OV);
         POE_E_TEMP:  duty_pm = 10'(POE_DUTY_TEMP);
         POE_E_CLIP:  duty_pm = 10'(POE_DUTY_CLIP);
         default:     duty_pm = 10'h000;
      endcase
   end

   // ------------------------------------------------------------------
   // Period tables, folded at elaboration
   // ------------------------------------------------------------------
   wire [23:0] pwm_tab [8];
   wire [23:0] sent_tab [8];
   for (genvar i = 0; i < 8; i++) begin : g_tab
      assign pwm_tab[i]  = 24'(CLK_HZ / POE_PWM_HZ[i]);
      assign sent_tab[i] = 24'(CLK_HZ / POE_SENT_HZ[i]);
   end

   wire        sent_mode = setup_reg[POE_B_SENT_MODE];
   wire [2:0]  code      = format_reg[2:0];
   wire        pol       = format_reg[POE_B_POL];
   wire        pause     = format_reg[6:POE_B_PAUSE_LO] == 3'b000;
   // PWM errors only; SENT carries codes in its frames
   wire        pwm_err   = ~sent_mode & (err_code_reg != POE_E_NONE);
   // Half frequency means twice the period
   wire [23:0] per_base  = sent_mode ? sent_tab[code] : pwm_tab[code];
   wire [23:0] per       = pwm_err ? {per_base[22:0], 1'b0} : per_base;
   // Fast two codes drop the last value bit
   wire [11:0] val       = code[2:1] == 2'b00 ? {lin_reg[11:1], 1'b0}
                                              : lin_reg;
   wire [35:0] dn_full   = per * val;
   wire [33:0] de_full   = per * duty_pm;
   wire [23:0] duty_cyc  = pwm_err ? 24'(de_full / 34'(POE_DUTY_FULL))
                                   : dn_full[35:12];
   // Band bit turns overvoltage into a held low output
   wire hold_low = uv | (pwm_err & err_code_reg == POE_E_OV
                         & setup_reg[POE_B_ERR_BAND]);

   logic [23:0] cnt_reg;
   wire wrap = cnt_reg >= per - 24'h00_0001;
   wire [23:0] cnt_next = (wrap | uv) ? 24'h00_0000 : cnt_reg + 24'h00_0001;
   // Active phase level is the opening edge's result
   wire act_lvl = pol;
   wire pwm_next = hold_low ? 1'b0
                 : (cnt_next < duty_cyc) ? act_lvl : ~act_lvl;
   wire frame_next = sent_mode & pause & wrap & ~uv;

   // Events for the interrupt: error onset, error gone, frame tick
   wire [2:0] ev = {frame_next,
                    err_code_reg != POE_E_NONE & err_next == POE_E_NONE,
                    err_code_reg == POE_E_NONE & err_next != POE_E_NONE};
   wire [2:0] clr = (wr_acc & hit_clr) ? pwdata[2:0] : 3'b000;

   // ------------------------------------------------------------------
   // Output and state flops
   // ------------------------------------------------------------------
   logic pwm_reg, oe_n_reg, irq_reg, tick_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lin_reg      <= 12'h000;
         err_code_reg <= POE_E_NONE;
         cnt_reg      <= 24'h00_0000;
         pwm_reg      <= 1'b0;
         oe_n_reg     <= 1'b0;
         tick_reg     <= 1'b0;
         stat_reg     <= 3'b000;
         irq_reg      <= 1'b0;
      end else begin
         lin_reg      <= lin_next;
         err_code_reg <= err_next;
         cnt_reg      <= sent_mode & ~pause ? 24'h00_0000 : cnt_next;
         pwm_reg      <= sent_mode ? 1'b0 : pwm_next;
         // Open drain releases high; driven low on undervoltage
         oe_n_reg     <= format_reg[POE_B_OPEN_DR] & pwm_next & ~uv
                         & ~sent_mode;
         tick_reg     <= frame_next;
         // Set beats a clear landing in the same cycle
         stat_reg     <= (stat_reg & ~clr) | ev;
         irq_reg      <= |(((stat_reg & ~clr) | ev) & en_reg);
      end
   end

   assign prdata          = prdata_reg;
   assign pready          = pready_reg;
   assign pslverr         = pslverr_reg;
   assign pwm_out         = pwm_reg;
   assign pwm_oe_n        = oe_n_reg;
   assign irq             = irq_reg;
   assign lin_value       = lin_reg;
   assign sent_frame_tick = tick_reg;
   assign err_code        = err_code_reg;

   // SENT format flags straight from flops
   logic sel_reg, six_reg, lay_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg <= 1'b0;
         six_reg <= 1'b0;
         lay_reg <= 1'b0;
      end else begin
         sel_reg <= sent_mode;
         six_reg <= sent_mode & pol;
         lay_reg <= format_reg[POE_B_LAYOUT];
      end
   end
   assign sent_select = sel_reg;
   assign sent_six    = six_reg;
   assign sent_layout = lay_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   // Opening edge of each period follows the polarity bit
   chk_pol_open: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!sent_mode && !hold_low && wrap && duty_cyc != 0 && $stable(pol))
      |=> pwm_out == pol)
      else $error("PWM period opened with wrong edge");

   chk_six_nib: assert property (
      @(posedge pclk) disable iff (!presetn)
      sent_mode |=> sent_six == $past(pol))
      else $error("SENT nibble count wrong");

   // Periods held against the frequency table, not the doubling logic
   chk_per_half: assert property (
      @(posedge pclk) disable iff (!presetn)
      pwm_err |-> per == 24'(2 * (CLK_HZ / POE_PWM_HZ[code])))
      else $error("error period not doubled");

   chk_mem_duty: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pwm_err && err_code_reg == POE_E_MEM)
      |-> duty_cyc == 24'(per * POE_DUTY_MEM / POE_DUTY_FULL))
      else $error("memory failure duty wrong");

   chk_field_duty: assert property (
      @(posedge pclk) disable iff (!presetn)
      (shown && !uv && fail[POE_F_FLOW] && !(|fail[4:0]))
      ##1 (err_code_reg == POE_E_FLOW) |-> duty_pm == 10'd625)
      else $error("low field duty wrong");

   chk_ov_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!sent_mode && err_code_reg == POE_E_OV && setup_reg[7]
       && $stable(err_code_reg)) |=> !pwm_out)
      else $error("overvoltage did not hold low");

   chk_uv_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      fail_in[POE_F_UV] |=> !pwm_out && !pwm_oe_n && err_code == POE_E_UV)
      else $error("undervoltage output not low");

   chk_nvm_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fail_in == 11'h001 && !setup_reg[2]) |=> err_code == POE_E_NONE)
      else $error("memory self-test ran while disabled");

   chk_mask_hide: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_reg[1] && !fail_in[POE_F_UV]) |=> err_code == POE_E_NONE)
      else $error("masked error shown");

   // SENT keeps its frame rate even while an error is shown
   chk_sent_code: assert property (
      @(posedge pclk) disable iff (!presetn)
      sent_mode |-> per == 24'(CLK_HZ / POE_SENT_HZ[code]))
      else $error("PWM error scheme used in SENT");

   chk_lin_seg: assert property (
      @(posedge pclk) disable iff (!presetn)
      (frac == 10'h000) |=> lin_value == $past(sp_lo))
      else $error("setpoint not hit at segment start");

   // Open drain only ever drives the low phase of the period
   chk_od_release: assert property (
      @(posedge pclk) disable iff (!presetn)
      (format_reg[POE_B_OPEN_DR] && !sent_mode && !uv)
      |=> pwm_oe_n == pwm_out)
      else $error("open drain did not release high");

   chk_tick_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      sent_frame_tick |=> !sent_frame_tick)
      else $error("frame tick longer than one cycle");
endmodule // poe_encoder

//--- logic/poe_pkg.sv
// Constants and register map of the position output encoder
// ----------------------------------------------------------------------
// Operation
// - PWM polarity bit 0 opens a period falling, bit 1 rising.
// - SENT: polarity bit 0 sends three nibbles, 1 sends six.
// - Period field picks PWM 2.0 kHz down to 200 Hz; fast two 11-bit.
// - SENT with pause pulse: same field picks frame rate 8 to 0.5 kHz.
// - Linearization curve has 32 equal segments bounded by 33 setpoints.
// - Output interpolates linearly between the two bounding setpoints.
// - Setpoints sit at input multiples of 1024; last at 32767; the code puts the last at 32768, so input 32767 falls just short of it.
// - PWM failure halves the frequency; duty cycle names the failure.
// - Memory, ROM, stuck, self-test, supply monitor failures give 95%.
// - Field too low gives 62.5%, field too high gives 55%.
// - Overvoltage gives 75%, or output held low when error band set.
// - Temperature error gives 85%, converter clipping gives 70%.
// - Undervoltage stops PWM, resets, and drives the output low.
// - Wire-break, undervoltage and driver thermal checks always active.
// - Memory self-test only runs when bit 2 of first setup is set.
// - In SENT mode errors go out as codes, not as duty cycles.
// - Six-nibble SENT format bit picks secure or second-channel layout.
// - Diagnosis mask bit hides errors; normal values keep flowing.
// ----------------------------------------------------------------------
package poe_pkg;
   // Register byte addresses
   localparam logic [7:0] POE_FIRST_SETUP_OFS = 8'h00;
   localparam logic [7:0] POE_FORMAT_OFS      = 8'h04;
   localparam logic [7:0] POE_SP_INDEX_OFS    = 8'h08;
   localparam logic [7:0] POE_SP_DATA_OFS     = 8'h0C;
   localparam logic [7:0] POE_CHECK_EN_OFS    = 8'h10;
   localparam logic [7:0] POE_IRQ_STAT_OFS    = 8'h14;
   localparam logic [7:0] POE_IRQ_CLR_OFS     = 8'h18;
   localparam logic [7:0] POE_IRQ_EN_OFS      = 8'h1C;
   localparam logic [7:0] POE_STATE_OFS       = 8'h20;
   // Reset values
   localparam logic [15:0] POE_FIRST_SETUP_RST = 16'h0000;
   localparam logic [15:0] POE_FORMAT_RST      = 16'h0000;
   localparam logic [10:0] POE_CHECK_EN_RST    = 11'h7FF;
   // Field positions, first setup
   localparam int POE_B_DIAG_MASK = 1;
   localparam int POE_B_NVM_TEST  = 2;
   localparam int POE_B_OV_DIS    = 3;
   localparam int POE_B_ERR_BAND  = 7;
   localparam int POE_B_SENT_MODE = 12;
   // Field positions, output format setup
   localparam int POE_B_POL       = 3;
   localparam int POE_B_PAUSE_LO  = 4;
   localparam int POE_B_OPEN_DR   = 7;
   localparam int POE_B_LAYOUT    = 12;
   // Failure inputs in priority order, except undervoltage at 9, which outranks all
   localparam int POE_F_NVM = 0, POE_F_ROM = 1, POE_F_STUCK = 2;
   localparam int POE_F_FSM = 3, POE_F_SUPMON = 4, POE_F_FLOW = 5;
   localparam int POE_F_FHIGH = 6, POE_F_OV = 7, POE_F_TEMP = 8;
   localparam int POE_F_UV = 9, POE_F_CLIP = 10, POE_NFAIL = 11;
   // Linearization
   localparam int POE_NSP       = 33;
   localparam int POE_SEG_SHIFT = 10;
   // Frequencies in Hz per period code
   localparam int POE_PWM_HZ [8] = '{2000, 1600, 1000, 800, 500, 400,
                                     250, 200};
   localparam int POE_SENT_HZ [8] = '{8000, 4000, 2660, 2000, 1600,
                                      1000, 800, 500};
   // Error duty cycles in tenths of a percent
   localparam int POE_DUTY_MEM   = 950;
   localparam int POE_DUTY_FLOW  = 625;
   localparam int POE_DUTY_FHIGH = 550;
   localparam int POE_DUTY_OV    = 750;
   localparam int POE_DUTY_TEMP  = 850;
   localparam int POE_DUTY_CLIP  = 700;
   localparam int POE_DUTY_FULL  = 1000;
   // Error codes shown on the state register and SENT side
   typedef enum logic [2:0] {
      POE_E_NONE  = 3'b000,
      POE_E_MEM   = 3'b001,
      POE_E_FLOW  = 3'b010,
      POE_E_FHIGH = 3'b011,
      POE_E_OV    = 3'b100,
      POE_E_TEMP  = 3'b101,
      POE_E_UV    = 3'b110,
      POE_E_CLIP  = 3'b111
   } poe_err_t;
endpackage

//--- sim/poe_ctrl_model.sv
// Control unit model that times the encoder's output line
`timescale 1ns/1ps
module poe_ctrl_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pwm_out,
   input  wire logic pwm_oe_n,
   output int        period,
   output int        low_time
);
   logic line;
   logic line_q;
   int   cnt;
   int   lcnt;

   // Pull-up holds the line high whenever the driver lets go
   assign line = pwm_oe_n ? 1'b1 : pwm_out;

   // ------------------------------------------------------------------
   // Period from falling edge to falling edge, low cycles within it
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q   <= 1'b0;
         cnt      <= 0;
         lcnt     <= 0;
         period   <= 0;
         low_time <= 0;
      end else begin
         line_q <= line;
         if (line_q && !line) begin
            period   <= cnt;
            low_time <= lcnt;
            cnt      <= 1;
            lcnt     <= 1;
         end else begin
            cnt  <= cnt + 1;
            lcnt <= lcnt + int'(!line);
         end
      end
   end
endmodule // poe_ctrl_model

//--- sim/test_position_output_encoder.sv
// Self-checking testbench of the position output encoder
`timescale 1ns/1ps
module test_position_output_encoder;
   import poe_pkg::*;
   // Slow clock keeps the slow PWM codes short; fine resolution is lost
   localparam int CLK = 1_000_000;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] q;
   logic        pready, pslverr, e, pwm_out, pwm_oe_n, irq, tick;
   logic        sent_select, sent_six, sent_layout;
   logic [14:0] position = 15'h0000;
   logic [10:0] fail_in = 11'h000;
   logic [11:0] lin_value;
   logic [2:0]  err_code;
   logic [11:0] sp [33];
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          period, low_time, lp, per;
   int          pos [5] = '{0, 512, 1324, 20000, 32767};
   int          code [11] = '{1, 1, 1, 1, 1, 2, 3, 4, 5, 6, 7};
   int          ebit [4] = '{5, 7, 8, 10};
   int          epm [4] = '{625, 750, 850, 700};
   int          sent_c [3] = '{0, 2, 7};

   always #4 pclk = ~pclk;

   poe_encoder #(.CLK_HZ(CLK)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .position(position), .fail_in(fail_in),
      .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .irq(irq),
      .lin_value(lin_value), .sent_select(sent_select),
      .sent_six(sent_six), .sent_layout(sent_layout),
      .sent_frame_tick(tick), .err_code(err_code));

   poe_ctrl_model ecu (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
      .pwm_oe_n(pwm_oe_n), .period(period), .low_time(low_time));

   // ------------------------------------------------------------------
   // Bus, compare and timing tasks
   // ------------------------------------------------------------------
   task automatic print_verdict;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask

   // Measured times allow one cycle of slack at the edges
   task automatic chk_t(input string nm, input int x, input int g);
      n_tests++;
      if (g < x - 1 || g > x + 1) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0d seen %0d", nm, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k == 20) n_mismatch++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, x, q);
   endtask

   task automatic fail(input logic [10:0] f);
      fail_in <= f;
      repeat (3) @(posedge pclk);
   endtask

   // Two full periods settle the line before the model's figures count
   task automatic measure(input int p, input int lo);
      repeat (2 * p + 20) @(posedge pclk);
      chk_t("period", p, period);
      chk_t("low time", lo, low_time);
   endtask

   task automatic quiet(input string nm);
      int h;
      h = 0;
      repeat (3000) begin
         @(posedge pclk);
         h += int'(pwm_out !== 1'b0);
      end
      chk(nm, 32'h0000_0000, 32'(h));
   endtask

   task automatic tick_gap(input int x);
      int k;
      k = 0;
      while (tick !== 1'b1 && k < 5000) begin
         @(posedge pclk);
         k++;
      end
      k = 0;
      @(posedge pclk);
      while (tick !== 1'b1 && k < 5000) begin
         @(posedge pclk);
         k++;
      end
      chk_t("frame gap", x, k + 1);
   endtask

   function automatic int lin(input int p);
      int s;
      s = p >> 10;
      return (int'(sp[s]) + (((int'(sp[s+1]) - int'(sp[s]))
              * (p % 1024)) >> 10)) & 'hFFF;
   endfunction

   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(POE_FIRST_SETUP_OFS, 32'h0000_0000, "first setup");
      rd(POE_CHECK_EN_OFS, 32'h0000_07FF, "check enable");
      rd(8'h40, 32'h0000_0000, "unmapped");
      chk("unmapped error", 32'h0000_0001, 32'(e));
      wr(POE_SP_INDEX_OFS, 32'h0000_0000);
      for (int i = 0; i < 33; i++) begin
         sp[i] = 12'(i * i * 3);
         wr(POE_SP_DATA_OFS, 32'(sp[i]));
      end
      wr(POE_SP_DATA_OFS, 32'h0000_0FFF);
      rd(POE_SP_DATA_OFS, 32'h0000_0000, "beyond table");
      foreach (pos[i]) begin
         position <= 15'(pos[i]);
         repeat (3) @(posedge pclk);
         chk("lin value", 32'(lin(pos[i])), 32'(lin_value));
         rd(POE_STATE_OFS, 32'(lin(pos[i])), "state");
      end
      lp = lin(20000);
      position <= 15'd20000;
      for (int c = 0; c < 8; c++) begin
         per = CLK / POE_PWM_HZ[c];
         wr(POE_FORMAT_OFS, 32'(c));
         measure(per, per * (c < 2 ? lp & 'hFFE : lp) >> 12);
      end
      per = CLK / POE_PWM_HZ[0];
      wr(POE_FORMAT_OFS, 32'h0000_0008);
      measure(per, per - (per * (lp & 'hFFE) >> 12));
      // Open drain: pull-up carries the released high phase
      wr(POE_FORMAT_OFS, 32'h0000_0080);
      measure(per, per * (lp & 'hFFE) >> 12);
      wr(POE_FORMAT_OFS, 32'h0000_0000);
      // Interrupt: masked, enabled, cleared
      fail(11'h020);
      chk("irq masked", 32'h0000_0000, 32'(irq));
      rd(POE_IRQ_STAT_OFS, 32'h0000_0001, "status");
      wr(POE_IRQ_EN_OFS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk("irq set", 32'h0000_0001, 32'(irq));
      wr(POE_IRQ_CLR_OFS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk("irq clear", 32'h0000_0000, 32'(irq));
      foreach (ebit[i]) begin
         fail(11'(1 << ebit[i]));
         measure(2*per, 2*per*epm[i]/1000);
      end
      fail(11'h001);
      chk("memory test off", 32'h0000_0000, 32'(err_code));
      wr(POE_FIRST_SETUP_OFS, 32'h0000_0004);
      // Undervoltage is a reset and is checked last
      for (int i = 0; i < 11; i++) begin
         if (i == 9)
            continue;
         fail(11'(1 << i));
         chk("err", 32'(code[i]), 32'(err_code));
      end
      fail(11'h520);
      chk("priority", 32'h0000_0002, 32'(err_code));
      fail(11'h500);
      chk("priority", 32'h0000_0005, 32'(err_code));
      wr(POE_CHECK_EN_OFS, 32'h0000_06FF);
      fail(11'h100);
      chk("check off", 32'h0000_0000, 32'(err_code));
      wr(POE_CHECK_EN_OFS, 32'h0000_07FF);
      wr(POE_FIRST_SETUP_OFS, 32'h0000_0084);
      fail(11'h080);
      quiet("error band line");
      wr(POE_FIRST_SETUP_OFS, 32'h0000_0006);
      fail(11'h100);
      measure(per, per * (lp & 'hFFE) >> 12);
      // SENT selection, frame content and frame rate
      wr(POE_FIRST_SETUP_OFS, 32'h0000_1004);
      wr(POE_FORMAT_OFS, 32'h0000_1008);
      fail(11'h020);
      chk("sent select", 32'h0000_0001, 32'(sent_select));
      chk("six nibbles", 32'h0000_0001, 32'(sent_six));
      chk("layout", 32'h0000_0001, 32'(sent_layout));
      quiet("sent line");
      foreach (sent_c[i]) begin
         wr(POE_FORMAT_OFS, 32'(sent_c[i]));
         tick_gap(CLK / POE_SENT_HZ[sent_c[i]]);
      end
      chk("three nibbles", 32'h0000_0000, 32'(sent_six));
      // Onset, error gone and frame tick have all been seen by now
      rd(POE_IRQ_STAT_OFS, 32'h0000_0007, "status all");
      wr(POE_FIRST_SETUP_OFS, 32'h0000_0000);
      fail(11'h200);
      chk("undervoltage", 32'h0000_0006, 32'(err_code));
      quiet("undervoltage line");
      chk("line driven", 32'h0000_0000, 32'(pwm_oe_n));
      print_verdict();
   end

   // Watchdog well past the expected run length
   initial begin
      repeat (90_000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
endmodule // test_position_output_encoder
